// *** rtl/spcr_device.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "spcr_map.svh"
module spcr_device
  import spcr_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  spcr_if.dev spi,
  input wire logic [1:0] i_chan_sel,
  output logic o_soft_reset,
  output logic o_datapath_reset,
  output logic o_lsb_first,
  output logic o_addr_inc,
  output logic [3:0] o_pwr_mode,
  output logic [1:0] o_dp_clk_en,
  output logic [1:0] o_dp_hold_rst,
  output logic [1:0] o_link_en
);

  spcr_dev_t q;
  spcr_dev_t next_q;
  logic rise;
  logic fall;
  logic bit_in;
  logic [15:0] sh;
  logic [7:0] wbyte;

  // ==========================================================
  // Register read view
  function automatic logic [7:0] read_val(input logic [14:0] a, input spcr_dev_t s,
                                          input logic [1:0] sel);
    logic [7:0] v;
    v = 8'h00;
    unique case (a)
      `SPCR_ADDR_CFG_A: begin
        v[`SPCR_BIT_LSB] = s.lsb;
        v[`SPCR_BIT_LSB_M] = s.lsb;
        v[`SPCR_BIT_INC] = s.inc;
        v[`SPCR_BIT_INC_M] = s.inc;
      end
      `SPCR_ADDR_PWR: begin
        // Both selected reads the first channel
        v[1:0] = (sel == 2'h2) ? s.pwr[1] : s.pwr[0];
      end
      default: begin
        v = 8'h00;
      end
    endcase
    return v;
  endfunction

  // ==========================================================
  // Next state
  always_comb begin
    next_q = q;
    rise = 1'b0;
    fall = 1'b0;
    sh = 16'h0000;
    wbyte = 8'h00;
    next_q.sy0 = {spi.sdio, spi.chip_select_n, spi.sclk};
    next_q.sy1 = q.sy0;
    next_q.sy2 = q.sy1;
    // A pin level counts once the second and third stages agree, so one stray sample is ignored
    for (int i = 0; i < 3; i++) begin
      if (q.sy1[i] == q.sy2[i]) begin
        next_q.flt[i] = q.sy2[i];
      end
    end
    rise = (q.sy1[0] == q.sy2[0]) && q.sy2[0] && !q.flt[0];
    fall = (q.sy1[0] == q.sy2[0]) && !q.sy2[0] && q.flt[0];
    bit_in = next_q.flt[2];
    next_q.srst = 1'b0;
    next_q.dp_rst = 1'b0;
    // Shift direction follows the bit order for instruction and data alike
    sh = q.lsb ? {bit_in, q.sr[15:1]} : {q.sr[14:0], bit_in};
    if (next_q.flt[1]) begin
      next_q.st = DS_IDLE;
      next_q.drive = 1'b0;
      next_q.cnt = 4'h0;
    end else begin
      unique case (q.st)
        DS_IDLE: begin
          next_q.st = DS_INSTR;
          next_q.cnt = 4'h0;
        end
        DS_INSTR: begin
          if (rise) begin
            next_q.sr = sh;
            next_q.cnt = q.cnt + 4'h1;
            if (q.cnt == 4'hF) begin
              next_q.rd = sh[15];
              next_q.addr = sh[14:0];
              next_q.cnt = 4'h0;
              next_q.st = DS_DATA;
              // Reply byte is fetched now, a half period before its first bit goes out
              next_q.tx = read_val(sh[14:0], q, i_chan_sel);
            end
          end
        end
        DS_DATA: begin
          // Reply bits change on the falling edge so they settle before the host samples
          if (fall && q.rd) begin
            next_q.drive = 1'b1;
            next_q.sdo = q.lsb ? q.tx[q.cnt[2:0]] : q.tx[3'h7 - q.cnt[2:0]];
          end
          if (rise) begin
            next_q.sr = sh;
            next_q.cnt = q.cnt + 4'h1;
            if (q.cnt == 4'h7) begin
              wbyte = q.lsb ? sh[15:8] : sh[7:0];
              next_q.cnt = 4'h0;
              if (!q.rd) begin
                unique case (q.addr)
                  `SPCR_ADDR_CFG_A: begin
                    if (wbyte[`SPCR_BIT_SRST] || wbyte[`SPCR_BIT_SRST_M]) begin
                      // Abandon the frame; the rest waits for deselect
                      next_q.lsb = `SPCR_LSB_RST;
                      next_q.inc = `SPCR_INC_RST;
                      next_q.pwr = {`SPCR_PWR_RST, `SPCR_PWR_RST};
                      next_q.st = DS_HALT;
                      next_q.srst = 1'b1;
                    end else begin
                      next_q.lsb = wbyte[`SPCR_BIT_LSB] | wbyte[`SPCR_BIT_LSB_M];
                      next_q.inc = wbyte[`SPCR_BIT_INC] | wbyte[`SPCR_BIT_INC_M];
                    end
                  end
                  `SPCR_ADDR_CFG_B: begin
                    next_q.dp_rst = wbyte[`SPCR_BIT_DP_RST];
                  end
                  `SPCR_ADDR_PWR: begin
                    for (int c = 0; c < 2; c++) begin
                      if (i_chan_sel[c]) begin
                        next_q.pwr[c] = wbyte[1:0];
                      end
                    end
                  end
                  default: begin
                    // Unlisted locations ignore writes
                    next_q.dp_rst = 1'b0;
                  end
                endcase
              end
              // Step the address for the next byte of a streamed transfer
              if (next_q.st == DS_DATA) begin
                next_q.addr = next_q.inc ? 15'(q.addr + 15'h0001) : 15'(q.addr - 15'h0001);
                next_q.tx = read_val(next_q.addr, next_q, i_chan_sel);
              end
            end
          end
        end
        DS_HALT: begin
          next_q.drive = 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q <= '0;
      // Pin stages start at idle levels so no false edge follows reset
      q.sy0 <= `SPCR_PIN_IDLE;
      q.sy1 <= `SPCR_PIN_IDLE;
      q.sy2 <= `SPCR_PIN_IDLE;
      q.flt <= `SPCR_PIN_IDLE;
    end else begin
      q <= next_q;
    end
  end

  // ==========================================================
  // Outputs
  // Enable is low only while the device drives the line
  assign spi.dev_sdio_o = q.sdo;
  assign spi.dev_sdio_oe_n = !q.drive;
  assign o_soft_reset = q.srst;
  assign o_datapath_reset = q.dp_rst;
  assign o_lsb_first = q.lsb;
  assign o_addr_inc = q.inc;
  assign o_pwr_mode = q.pwr;

  // ==========================================================
  // Channel decode
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_chan
      // Reserved code 01 is treated as normal operation
      assign o_dp_clk_en[g] = !q.pwr[g][1];
      assign o_dp_hold_rst[g] = (q.pwr[g] == `SPCR_PWR_DOWN);
      assign o_link_en[g] = (q.pwr[g] != `SPCR_PWR_DOWN);
    end
  endgenerate

endmodule
`default_nettype wire

// *** rtl/spcr_host.sv ***
// Register access over AHB-Lite was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "spcr_map.svh"
module spcr_host
  import spcr_pkg::*;
#(
  parameter int HALF_CYC = `SPCR_HALF_CYC,
  parameter int SRST_WAIT_CYC = `SPCR_SRST_WAIT_CYC
) (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [31:0] o_hrdata,
  spcr_if.host spi
);

  spcr_host_t q;
  spcr_host_t next_q;
  logic [23:0] stream;
  logic [7:0] data;
  logic [14:0] addr;
  logic rd;
  logic half_done;

  function automatic logic [23:0] rev24(input logic [23:0] v);
    logic [23:0] r;
    r = 24'h00_0000;
    for (int i = 0; i < 24; i++) begin
      r[i] = v[23 - i];
    end
    return r;
  endfunction

  // ==========================================================
  // Next state
  always_comb begin
    next_q = q;
    stream = 24'h00_0000;
    data = 8'h00;
    addr = 15'h0000;
    rd = 1'b0;
    half_done = (q.div == 8'(HALF_CYC - 1));
    next_q.sy0 = spi.sdio;
    next_q.sy1 = q.sy0;
    next_q.sy2 = q.sy1;
    if (q.sy1 == q.sy2) begin
      next_q.flt = q.sy2;
    end
    if (q.wait_cnt != 20'h0_0000) begin
      next_q.wait_cnt = q.wait_cnt - 20'h0_0001;
    end
    next_q.dwr = 1'b0;
    if (q.dwr) begin
      unique case (q.dofs)
        `SPCR_HOFS_WDATA: begin
          next_q.wbyte = i_hwdata[7:0];
        end
        `SPCR_HOFS_STAT: begin
          if (i_hwdata[2]) begin
            next_q.refused = 1'b0;
          end
        end
        `SPCR_HOFS_CMD: begin
          rd = i_hwdata[`SPCR_CMD_READ];
          addr = i_hwdata[`SPCR_CMD_SRST] ? `SPCR_ADDR_CFG_A : i_hwdata[14:0];
          data = i_hwdata[`SPCR_CMD_SRST] ? `SPCR_SRST_CMD : q.wbyte;
          if (i_hwdata[`SPCR_CMD_SRST]) begin
            rd = 1'b0;
          end
          if (q.st != HS_IDLE) begin
            next_q.refused = 1'b1;
          end else if (!rd && (q.wait_cnt != 20'h0_0000)) begin
            next_q.refused = 1'b1;
          end else if (!rd && (addr > `SPCR_ADDR_PWR)) begin
            next_q.refused = 1'b1;
          end else begin
            stream = q.lsb ? rev24({data, rd, addr}) : {rd, addr, data};
            next_q.sr = stream;
            next_q.sdo = stream[23];
            next_q.drv = 1'b1;
            next_q.cs_n = 1'b0;
            next_q.rd = rd;
            next_q.addr = addr;
            next_q.wbyte = data;
            next_q.cnt = 5'h00;
            next_q.div = 8'h00;
            next_q.st = HS_SHIFT;
          end
        end
        default: begin
          next_q.dwr = 1'b0;
        end
      endcase
    end
    unique case (q.st)
      HS_IDLE: begin
        next_q.sclk = 1'b0;
      end
      HS_SHIFT: begin
        next_q.div = half_done ? 8'h00 : 8'(q.div + 8'h01);
        if (half_done && !q.sclk) begin
          if (q.cnt == 5'h18) begin
            next_q.cs_n = 1'b1;
            next_q.drv = 1'b0;
            next_q.st = HS_GAP;
            if (q.rd) begin
              next_q.rdata = q.rx;
            end else if (q.addr == `SPCR_ADDR_CFG_A) begin
              if (q.wbyte[`SPCR_BIT_SRST] || q.wbyte[`SPCR_BIT_SRST_M]) begin
                next_q.lsb = `SPCR_LSB_RST;
                next_q.inc = `SPCR_INC_RST;
                next_q.wait_cnt = 20'(SRST_WAIT_CYC);
              end else begin
                next_q.lsb = q.wbyte[`SPCR_BIT_LSB] | q.wbyte[`SPCR_BIT_LSB_M];
                next_q.inc = q.wbyte[`SPCR_BIT_INC] | q.wbyte[`SPCR_BIT_INC_M];
              end
            end
          end else begin
            next_q.sclk = 1'b1;
            next_q.cnt = q.cnt + 5'h01;
            if (q.rd && (q.cnt >= 5'h10)) begin
              next_q.rx = q.lsb ? {q.flt, q.rx[7:1]} : {q.rx[6:0], q.flt};
            end
          end
        end else if (half_done) begin
          next_q.sclk = 1'b0;
          next_q.sr = {q.sr[22:0], 1'b0};
          next_q.sdo = q.sr[22];
          // Release the line before the device starts its reply
          if (q.rd && (q.cnt == 5'h10)) begin
            next_q.drv = 1'b0;
          end
        end
      end
      HS_GAP: begin
        next_q.div = half_done ? 8'h00 : 8'(q.div + 8'h01);
        if (half_done) begin
          next_q.st = HS_IDLE;
        end
      end
      default: begin
        next_q.st = HS_IDLE;
      end
    endcase
    if (i_hsel && i_htrans[1] && i_hready) begin
      next_q.dwr = i_hwrite && (i_haddr[31:8] == 24'h00_0000);
      next_q.dofs = i_haddr[7:0];
      if (!i_hwrite) begin
        next_q.hrdata = 32'h0000_0000;
        if (i_haddr[31:8] == 24'h00_0000) begin
          unique case (i_haddr[7:0])
            `SPCR_HOFS_WDATA: next_q.hrdata[7:0] = q.wbyte;
            `SPCR_HOFS_STAT: next_q.hrdata[4:0] = {q.inc, q.lsb, q.refused,
                                                   (q.wait_cnt != 20'h0_0000), (q.st != HS_IDLE)};
            `SPCR_HOFS_RDATA: next_q.hrdata[7:0] = q.rdata;
            default: next_q.hrdata = 32'h0000_0000;
          endcase
        end
      end
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q <= '0;
      q.cs_n <= 1'b1;
      q.sy0 <= 1'b1;
      q.sy1 <= 1'b1;
      q.sy2 <= 1'b1;
      q.flt <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;
  assign o_hrdata = q.hrdata;
  assign spi.sclk = q.sclk;
  assign spi.chip_select_n = q.cs_n;
  assign spi.host_sdio_o = q.sdo;
  assign spi.host_sdio_oe_n = !q.drv;

endmodule
`default_nettype wire

// *** rtl/spcr_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface spcr_if;
  logic sclk;
  logic chip_select_n;
  logic host_sdio_o;
  logic host_sdio_oe_n;
  logic dev_sdio_o;
  logic dev_sdio_oe_n;
  logic sdio;
  // Undriven line reads high, as with a pull-up
  assign sdio = !host_sdio_oe_n ? host_sdio_o : (!dev_sdio_oe_n ? dev_sdio_o : 1'b1);
  modport host (output sclk, output chip_select_n, output host_sdio_o, output host_sdio_oe_n, input sdio);
  modport dev (input sclk, input chip_select_n, input sdio, output dev_sdio_o, output dev_sdio_oe_n);
endinterface
`default_nettype wire

// *** rtl/spcr_map.svh ***
`ifndef SPCR_MAP_SVH
`define SPCR_MAP_SVH
`define SPCR_ADDR_CFG_A 15'h0000
`define SPCR_ADDR_CFG_B 15'h0001
`define SPCR_ADDR_PWR 15'h0002
`define SPCR_BIT_SRST 0
`define SPCR_BIT_SRST_M 7
`define SPCR_BIT_LSB 1
`define SPCR_BIT_LSB_M 6
`define SPCR_BIT_INC 2
`define SPCR_BIT_INC_M 5
`define SPCR_BIT_DP_RST 1
`define SPCR_LSB_RST 1'h0
`define SPCR_INC_RST 1'h0
`define SPCR_PWR_RST 2'h0
`define SPCR_PWR_NORMAL 2'h0
`define SPCR_PWR_STBY 2'h2
`define SPCR_PWR_DOWN 2'h3
`define SPCR_SRST_CMD 8'h81
`define SPCR_PIN_IDLE 3'h6
`define SPCR_SRST_WAIT_MS 5
`define SPCR_CLK_MHZ 125
`define SPCR_SRST_WAIT_CYC (`SPCR_SRST_WAIT_MS * 1000 * `SPCR_CLK_MHZ)
`define SPCR_HALF_CYC 12
`define SPCR_HOFS_CMD 8'h00
`define SPCR_HOFS_WDATA 8'h04
`define SPCR_HOFS_STAT 8'h08
`define SPCR_HOFS_RDATA 8'h0C
`define SPCR_CMD_READ 15
`define SPCR_CMD_SRST 16
`endif

// *** rtl/spcr_pkg.sv ***
package spcr_pkg;
  typedef enum logic [1:0] {DS_IDLE, DS_INSTR, DS_DATA, DS_HALT} spcr_dst_t;
  typedef enum logic [1:0] {HS_IDLE, HS_SHIFT, HS_GAP} spcr_hst_t;
  typedef struct packed {
    logic [2:0] sy0;
    logic [2:0] sy1;
    logic [2:0] sy2;
    logic [2:0] flt;
    spcr_dst_t st;
    logic [15:0] sr;
    logic [3:0] cnt;
    logic rd;
    logic [14:0] addr;
    logic [7:0] tx;
    logic sdo;
    logic drive;
    logic lsb;
    logic inc;
    logic [1:0][1:0] pwr;
    logic srst;
    logic dp_rst;
  } spcr_dev_t;
  typedef struct packed {
    spcr_hst_t st;
    logic [7:0] div;
    logic sclk;
    logic cs_n;
    logic sdo;
    logic drv;
    logic [23:0] sr;
    logic [4:0] cnt;
    logic rd;
    logic [14:0] addr;
    logic [7:0] wbyte;
    logic [7:0] rx;
    logic [7:0] rdata;
    logic lsb;
    logic inc;
    logic refused;
    logic [19:0] wait_cnt;
    logic sy0;
    logic sy1;
    logic sy2;
    logic flt;
    logic dwr;
    logic [7:0] dofs;
    logic [31:0] hrdata;
  } spcr_host_t;
endpackage

// *** verif/serial_port_config_registers_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "spcr_map.svh"
module serial_port_config_registers_tb_top;
  logic clk, rst_n, hsel, hwrite, hready, hresp, srst, dprst, lsb, inc;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0] htrans, sel, clken, hold, link;
  logic [2:0] hsize;
  logic [3:0] pwr;
  logic [1:0] modes [4] = '{2'h2, 2'h3, 2'h1, 2'h0};
  int error_cnt = 0;
  int n_compared = 0;
  int cyc = 0;
  int srst_seen = 0;
  int dp_seen = 0;
  spcr_if u_spcr_if ();
  spcr_host #(.SRST_WAIT_CYC(50)) u_spcr_host (.i_sys_clk(clk), .i_rst_n(rst_n), .i_hsel(hsel),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
    .i_hready(hready), .o_hreadyout(hready), .o_hresp(hresp), .o_hrdata(hrdata), .spi(u_spcr_if));
  spcr_device u_spcr_device (.i_sys_clk(clk), .i_rst_n(rst_n), .spi(u_spcr_if), .i_chan_sel(sel),
    .o_soft_reset(srst), .o_datapath_reset(dprst), .o_lsb_first(lsb), .o_addr_inc(inc),
    .o_pwr_mode(pwr), .o_dp_clk_en(clken), .o_dp_hold_rst(hold), .o_link_en(link));
  spcr_checker u_spcr_checker (.i_sys_clk(clk), .i_rst_n(rst_n), .sclk(u_spcr_if.sclk),
    .chip_select_n(u_spcr_if.chip_select_n), .host_sdio_oe_n(u_spcr_if.host_sdio_oe_n),
    .dev_sdio_oe_n(u_spcr_if.dev_sdio_oe_n), .o_soft_reset(srst), .o_datapath_reset(dprst),
    .o_lsb_first(lsb), .o_addr_inc(inc), .o_pwr_mode(pwr), .o_dp_clk_en(clken),
    .o_dp_hold_rst(hold), .o_link_en(link));
  // ==========================================================
  // Clock, timeout and pulse counters
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (srst === 1'b1) srst_seen++;
    if (dprst === 1'b1) dp_seen++;
    if (cyc == 60000) begin
      error_cnt++;
      end_sim();
    end
  end
  // ==========================================================
  // Tasks
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    r = hrdata;
    chk("hresp", 32'h0000_0000, {31'h0000_0000, hresp});
  endtask
  // Busy or wait flags must drop within a bounded number of polls
  task automatic wait_stat(input int b);
    for (int i = 0; i < 400; i++) begin
      ahb(1'b0, `SPCR_HOFS_STAT, 32'h0000_0000);
      if (r[b] === 1'b0) return;
    end
    chk("stat wait", 32'h0000_0000, 32'h0000_0001);
  endtask
  task automatic dev(input logic rd, input logic [14:0] a, input logic [7:0] d);
    ahb(1'b1, `SPCR_HOFS_WDATA, {24'h00_0000, d});
    ahb(1'b1, `SPCR_HOFS_CMD, {16'h0000, rd, a});
    wait_stat(0);
    if (rd) ahb(1'b0, `SPCR_HOFS_RDATA, 32'h0000_0000);
  endtask
  task automatic rchk(input string nm, input logic [14:0] a, input logic [7:0] e);
    dev(1'b1, a, 8'h00);
    chk(nm, {24'h00_0000, e}, {24'h00_0000, r[7:0]});
  endtask
  // ==========================================================
  // Sequence
  initial begin
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    sel = 2'h1;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk("outs", 32'h0000_0000, {24'h00_0000, lsb, inc, pwr, srst, dprst});
    for (int a = 0; a < 3; a++) rchk("reset val", a[14:0], 8'h00);
    // Reserved code 01 must decode as normal operation
    for (int i = 0; i < 4; i++) begin
      dev(1'b0, 15'h0002, {6'h00, modes[i]});
      chk("pwr a", {28'h000_0000, 2'h0, modes[i]}, {28'h000_0000, pwr});
      chk("decode", 32'({~modes[i][1], &modes[i], ~&modes[i]}), 32'({clken[0], hold[0], link[0]}));
    end
    sel <= 2'h3;
    dev(1'b0, 15'h0002, 8'h02);
    chk("pwr both", 32'h0000_000A, {28'h000_0000, pwr});
    sel <= 2'h2;
    dev(1'b0, 15'h0002, 8'h03);
    chk("pwr b", 32'h0000_000E, {28'h000_0000, pwr});
    chk("gates", 32'h0000_0009, {26'h000_0000, clken, hold, link});
    sel <= 2'h3;
    rchk("read both", 15'h0002, 8'h02);
    sel <= 2'h2;
    rchk("read b", 15'h0002, 8'h03);
    dev(1'b0, 15'h0000, 8'h20);
    chk("inc mirror", 32'h0000_0001, {31'h0000_0000, inc});
    rchk("cfg a inc", 15'h0000, 8'h24);
    dev(1'b0, 15'h0000, 8'h42);
    chk("lsb", 32'h0000_0002, {30'h0000_0000, lsb, inc});
    rchk("cfg a lsb", 15'h0000, 8'h42);
    dev(1'b0, 15'h0001, 8'hFF);
    chk("dp pulses", 32'h0000_0001, dp_seen);
    rchk("cfg b", 15'h0001, 8'h00);
    dev(1'b0, 15'h0003, 8'h55);
    ahb(1'b0, `SPCR_HOFS_STAT, 32'h0000_0000);
    chk("refused", 32'h0000_0001, {31'h0000_0000, r[2]});
    ahb(1'b1, `SPCR_HOFS_STAT, 32'h0000_0004);
    ahb(1'b0, 8'h10, 32'h0000_0000);
    chk("unmapped", 32'h0000_0000, r);
    ahb(1'b1, `SPCR_HOFS_CMD, 32'h0001_0000);
    wait_stat(0);
    // A write inside the recovery wait must be turned away
    dev(1'b0, 15'h0002, 8'h02);
    ahb(1'b0, `SPCR_HOFS_STAT, 32'h0000_0000);
    chk("wait refuse", 32'h0000_0001, {31'h0000_0000, r[2]});
    wait_stat(1);
    chk("srst", 32'h0000_0001, srst_seen);
    chk("srst outs", 32'h0000_0000, {26'h000_0000, lsb, inc, pwr});
    rchk("cfg a srst", 15'h0000, 8'h00);
    dev(1'b0, 15'h0000, 8'h80);
    chk("srst mirror", 32'h0000_0002, srst_seen);
    wait_stat(1);
    rchk("cfg a mirror", 15'h0000, 8'h00);
    end_sim();
  end
endmodule
`default_nettype wire

// *** verif/spcr_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module spcr_checker (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic sclk,
  input wire logic chip_select_n,
  input wire logic host_sdio_oe_n,
  input wire logic dev_sdio_oe_n,
  input wire logic o_soft_reset,
  input wire logic o_datapath_reset,
  input wire logic o_lsb_first,
  input wire logic o_addr_inc,
  input wire logic [3:0] o_pwr_mode,
  input wire logic [1:0] o_dp_clk_en,
  input wire logic [1:0] o_dp_hold_rst,
  input wire logic [1:0] o_link_en
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  // ==========================================================
  // Control outputs
  srst_pulse_a: assert property (o_soft_reset |=> !o_soft_reset)
    else $error("soft reset pulse longer than one cycle");
  srst_clears_a: assert property (o_soft_reset |-> !o_lsb_first && !o_addr_inc && o_pwr_mode == 4'h0)
    else $error("soft reset left settings in place");
  dp_pulse_a: assert property (o_datapath_reset |=> !o_datapath_reset)
    else $error("datapath reset pulse longer than one cycle");
  clk_gate_a: assert property (o_dp_clk_en == ~{o_pwr_mode[3], o_pwr_mode[1]})
    else $error("datapath clock enable wrong for power mode");
  hold_link_a: assert property (o_dp_hold_rst == {&o_pwr_mode[3:2], &o_pwr_mode[1:0]} && o_link_en == ~o_dp_hold_rst)
    else $error("hold or link enable wrong for power mode");
  // Settings only move inside a frame
  quiet_regs_a: assert property (chip_select_n [*8] |=> $stable(o_pwr_mode) && $stable(o_lsb_first) && $stable(o_addr_inc))
    else $error("settings changed outside a frame");
  // ==========================================================
  // Wire
  no_fight_a: assert property (host_sdio_oe_n || dev_sdio_oe_n)
    else $error("both ends drive the data line");
  host_idle_a: assert property (chip_select_n |-> !sclk && host_sdio_oe_n)
    else $error("host active outside a frame");
  dev_idle_a: assert property (chip_select_n [*8] |-> dev_sdio_oe_n)
    else $error("device drives data line outside a frame");
  half_period_a: assert property ($changed(sclk) |=> $stable(sclk) [*8])
    else $error("serial clock half period too short");
endmodule
`default_nettype wire
